// [include/csf_pkg.sv]
/*
  Constants for the cpu status flag block: flag positions, register
  offset, reset value, operation codes and addressing limits.
  Assumes a core clock and a simple register port beside it.
*/
// Notes on behaviour
// - Carry set on carry/borrow out of bit 7
// - Shifts load carry with last bit out
// - Set, clear, invert carry by command
// - Zero flag when 8-bit result is zero
// - Zero flag for bit tests and shifts
// - Sign flag copies result MSB
// - Overflow on signed 8-bit range exceed
// - Logic operations clear overflow
// - Decimal bit records last BCD kind; untestable
// - Half carry from bit 3 or 4
// - Decimal adjust uses half carry correction
// - Fast interrupt bit set, cleared on return
// - Fast bit blocks interrupts, fast return
// - Bank bit selects set-1 register bank
// - Bank zero clears, bank one sets
// - Register pairs even only, limits 14/254
// - Relative target is next address plus displacement
// - Short index adds signed 8-bit offset
// - Long index adds unsigned 16-bit offset
// - Bit operand: register 0-15, bit 0-7
// - Flag write collision left unresolved
package csf_pkg;
  localparam logic [7:0] CSF_FLAGS_OFS  = 8'hD5;
  localparam logic [7:0] CSF_FLAGS_RST  = 8'h00;
  localparam int         CSF_C_BIT      = 7;
  localparam int         CSF_Z_BIT      = 6;
  localparam int         CSF_S_BIT      = 5;
  localparam int         CSF_V_BIT      = 4;
  localparam int         CSF_D_BIT      = 3;
  localparam int         CSF_H_BIT      = 2;
  localparam int         CSF_FIS_BIT    = 1;
  localparam int         CSF_BANK_BIT   = 0;
  localparam logic [3:0] CSF_WPAIR_MAX  = 4'hE;
  localparam logic [7:0] CSF_RPAIR_MAX  = 8'hFE;
  localparam logic [3:0] CSF_WREG_MAX   = 4'hF;
  localparam logic [2:0] CSF_BITPOS_MAX = 3'h7;

  // Operation codes from the execution unit
  typedef enum logic [4:0] {
    CSF_OP_NONE  = 5'h00,
    CSF_OP_ADD   = 5'h01,
    CSF_OP_ADC   = 5'h02,
    CSF_OP_SUB   = 5'h03,
    CSF_OP_SBC   = 5'h04,
    CSF_OP_AND   = 5'h05,
    CSF_OP_OR    = 5'h06,
    CSF_OP_XOR   = 5'h07,
    CSF_OP_RL    = 5'h08,
    CSF_OP_RLC   = 5'h09,
    CSF_OP_RR    = 5'h0A,
    CSF_OP_RRC   = 5'h0B,
    CSF_OP_SRA   = 5'h0C,
    CSF_OP_BTEST = 5'h0D,
    CSF_OP_SCF   = 5'h0E,
    CSF_OP_RCF   = 5'h0F,
    CSF_OP_CCF   = 5'h10,
    CSF_OP_DADJ  = 5'h11,
    CSF_OP_SB0   = 5'h12,
    CSF_OP_SB1   = 5'h13
  } csf_op_e;

  // Fast interrupt tracking
  typedef enum logic [1:0] {
    CSF_ST_NORMAL = 2'b01,
    CSF_ST_FAST   = 2'b10
  } csf_state_e;
endpackage : csf_pkg

// [rtl/csf_status_flags.sv]
/*
  Status flag register and flag update datapath of the 8-bit core,
  with operand range checks and effective address adders.
  Assumes operations arrive as one-cycle strobes from the sequencer.
*/
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module csf_status_flags
  import csf_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  // Register port
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [7:0]  REG_RDATA_O,
  // Operation
  input  wire logic        OP_VALID_I,
  input  wire logic [4:0]  OP_CODE_I,
  input  wire logic [7:0]  OP_A_I,
  input  wire logic [7:0]  OP_B_I,
  input  wire logic [2:0]  OP_BIT_I,
  output logic      [7:0]  OP_RESULT_O,
  // Interrupt sequencing
  input  wire logic        FAST_INT_START_I,
  input  wire logic        INT_RETURN_I,
  output logic             INT_BLOCK_O,
  output logic             FAST_RETURN_O,
  // Flags and bank
  output logic      [7:0]  FLAGS_O,
  output logic             BANK_SEL_O,
  // Operand checks
  input  wire logic [3:0]  WPAIR_I,
  input  wire logic [7:0]  RPAIR_I,
  input  wire logic [3:0]  WREG_I,
  input  wire logic [2:0]  BITPOS_I,
  output logic             WPAIR_OK_O,
  output logic             RPAIR_OK_O,
  output logic             BITOPND_OK_O,
  // Address formation
  input  wire logic [15:0] NEXT_PC_I,
  input  wire logic [7:0]  DISP_I,
  input  wire logic [15:0] PAIR_VAL_I,
  input  wire logic [15:0] LONG_OFS_I,
  output logic      [15:0] REL_ADDR_O,
  output logic      [15:0] XS_ADDR_O,
  output logic      [15:0] XL_ADDR_O
);

  // Storage and control
  logic       [7:0] flags_ff;
  logic       [7:0] nxt_flags;
  logic       [7:0] result_ff;
  logic       [7:0] nxt_result;
  csf_state_e       state_ff;
  logic             flag_wr;
  logic             flag_rd;
  logic             fast_set;
  logic             fast_clr;

  // Adder unit
  logic             add_sub;
  logic             add_cin;
  logic       [8:0] add_sum;
  logic       [4:0] add_nib;
  logic             add_ovf;

  // Logic, shift, bit test and decimal adjust units
  logic       [7:0] log_res;
  logic       [7:0] shf_res;
  logic             shf_cout;
  logic       [7:0] tst_res;
  logic       [7:0] dadj_corr;
  logic       [7:0] dadj_res;
  logic             dadj_cout;

  // Operation classes
  logic             is_arith;
  logic             is_logic;
  logic             is_shift;
  logic             is_btest;
  logic             is_dadj;
  logic             is_carry_op;
  logic             is_bank_op;

  // Register port decode
  assign flag_wr = REG_WR_I && (REG_ADDR_I == CSF_FLAGS_OFS);
  assign flag_rd = REG_RD_I && (REG_ADDR_I == CSF_FLAGS_OFS);

  // Operation class decode
  always_comb begin
    is_arith    = 1'b0;
    is_logic    = 1'b0;
    is_shift    = 1'b0;
    is_btest    = 1'b0;
    is_dadj     = 1'b0;
    is_carry_op = 1'b0;
    is_bank_op  = 1'b0;
    if (OP_VALID_I) begin
      case (OP_CODE_I)
        CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC: begin
          is_arith = 1'b1;
        end
        CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR: begin
          is_logic = 1'b1;
        end
        CSF_OP_RL, CSF_OP_RLC, CSF_OP_RR, CSF_OP_RRC, CSF_OP_SRA: begin
          is_shift = 1'b1;
        end
        CSF_OP_BTEST: begin
          is_btest = 1'b1;
        end
        CSF_OP_DADJ: begin
          is_dadj = 1'b1;
        end
        CSF_OP_SCF, CSF_OP_RCF, CSF_OP_CCF: begin
          is_carry_op = 1'b1;
        end
        CSF_OP_SB0, CSF_OP_SB1: begin
          is_bank_op = 1'b1;
        end
        default: begin
          is_arith = 1'b0;
        end
      endcase
    end
  end

  // Adder unit; subtraction borrows through the same chain
  always_comb begin
    add_sub = (OP_CODE_I == CSF_OP_SUB) || (OP_CODE_I == CSF_OP_SBC);
    add_cin = 1'b0;
    if ((OP_CODE_I == CSF_OP_ADC) || (OP_CODE_I == CSF_OP_SBC)) begin
      add_cin = flags_ff[CSF_C_BIT];
    end
    if (add_sub) begin
      add_sum = {1'b0, OP_A_I} - {1'b0, OP_B_I} - {8'h00, add_cin};
      add_nib = {1'b0, OP_A_I[3:0]} - {1'b0, OP_B_I[3:0]} - {4'h0, add_cin};
      add_ovf = (OP_A_I[7] != OP_B_I[7]) && (add_sum[7] != OP_A_I[7]);
    end else begin
      add_sum = {1'b0, OP_A_I} + {1'b0, OP_B_I} + {8'h00, add_cin};
      add_nib = {1'b0, OP_A_I[3:0]} + {1'b0, OP_B_I[3:0]} + {4'h0, add_cin};
      add_ovf = (OP_A_I[7] == OP_B_I[7]) && (add_sum[7] != OP_A_I[7]);
    end
  end

  // Logic unit
  always_comb begin
    case (OP_CODE_I)
      CSF_OP_AND: begin
        log_res = OP_A_I & OP_B_I;
      end
      CSF_OP_OR: begin
        log_res = OP_A_I | OP_B_I;
      end
      default: begin
        log_res = OP_A_I ^ OP_B_I;
      end
    endcase
  end

  // Rotate and shift unit
  always_comb begin
    case (OP_CODE_I)
      CSF_OP_RL: begin
        shf_res  = {OP_A_I[6:0], OP_A_I[7]};
        shf_cout = OP_A_I[7];
      end
      CSF_OP_RLC: begin
        shf_res  = {OP_A_I[6:0], flags_ff[CSF_C_BIT]};
        shf_cout = OP_A_I[7];
      end
      CSF_OP_RR: begin
        shf_res  = {OP_A_I[0], OP_A_I[7:1]};
        shf_cout = OP_A_I[0];
      end
      CSF_OP_RRC: begin
        shf_res  = {flags_ff[CSF_C_BIT], OP_A_I[7:1]};
        shf_cout = OP_A_I[0];
      end
      CSF_OP_SRA: begin
        shf_res  = {OP_A_I[7], OP_A_I[7:1]};
        shf_cout = OP_A_I[0];
      end
      default: begin
        shf_res  = OP_A_I;
        shf_cout = flags_ff[CSF_C_BIT];
      end
    endcase
  end

  // Bit test unit
  assign tst_res = {7'h00, OP_A_I[OP_BIT_I]};

  // Decimal adjust unit, correction picked by half carry and carry
  always_comb begin
    dadj_corr = 8'h00;
    if (flags_ff[CSF_H_BIT] || (OP_A_I[3:0] > 4'h9)) begin
      dadj_corr[3:0] = 4'h6;
    end
    if (flags_ff[CSF_C_BIT] || (OP_A_I > 8'h99)) begin
      dadj_corr[7:4] = 4'h6;
    end
    if (flags_ff[CSF_D_BIT]) begin
      dadj_res  = OP_A_I - dadj_corr;
      dadj_cout = flags_ff[CSF_C_BIT];
    end else begin
      dadj_res  = OP_A_I + dadj_corr;
      dadj_cout = flags_ff[CSF_C_BIT] || (OP_A_I > 8'h99);
    end
  end

  // Result select
  always_comb begin
    nxt_result = OP_A_I;
    if (is_arith) begin
      nxt_result = add_sum[7:0];
    end else if (is_logic) begin
      nxt_result = log_res;
    end else if (is_shift) begin
      nxt_result = shf_res;
    end else if (is_btest) begin
      nxt_result = tst_res;
    end else if (is_dadj) begin
      nxt_result = dadj_res;
    end
  end

  // Fast interrupt bit set and clear requests
  assign fast_set = FAST_INT_START_I;
  assign fast_clr = INT_RETURN_I && (state_ff == CSF_ST_FAST);

  // Flag merge; op updates win over a software write
  always_comb begin
    nxt_flags = flags_ff;
    if (flag_wr) begin
      nxt_flags = REG_WDATA_I;
    end
    if (is_arith) begin
      nxt_flags[CSF_C_BIT] = add_sum[8];
      nxt_flags[CSF_H_BIT] = add_nib[4];
      nxt_flags[CSF_V_BIT] = add_ovf;
      nxt_flags[CSF_D_BIT] = add_sub;
    end
    if (is_logic) begin
      nxt_flags[CSF_V_BIT] = 1'b0;
    end
    if (is_shift) begin
      nxt_flags[CSF_C_BIT] = shf_cout;
    end
    if (is_dadj) begin
      nxt_flags[CSF_C_BIT] = dadj_cout;
    end
    // Carry commands ignore any result
    if (is_carry_op) begin
      case (OP_CODE_I)
        CSF_OP_SCF: begin
          nxt_flags[CSF_C_BIT] = 1'b1;
        end
        CSF_OP_RCF: begin
          nxt_flags[CSF_C_BIT] = 1'b0;
        end
        default: begin
          nxt_flags[CSF_C_BIT] = ~flags_ff[CSF_C_BIT];
        end
      endcase
    end
    if (is_bank_op) begin
      nxt_flags[CSF_BANK_BIT] = (OP_CODE_I == CSF_OP_SB1);
    end
    // Zero and sign follow the selected result
    if (is_arith || is_logic || is_shift || is_dadj) begin
      nxt_flags[CSF_Z_BIT] = (nxt_result == 8'h00);
      nxt_flags[CSF_S_BIT] = nxt_result[7];
    end
    if (is_btest) begin
      nxt_flags[CSF_Z_BIT] = (tst_res == 8'h00);
    end
    // Start wins over a return in the same cycle
    if (fast_clr) begin
      nxt_flags[CSF_FIS_BIT] = 1'b0;
    end
    if (fast_set) begin
      nxt_flags[CSF_FIS_BIT] = 1'b1;
    end
  end

  // Flags register
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flags_ff <= CSF_FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Result register
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      result_ff <= 8'h00;
    end else if (OP_VALID_I) begin
      result_ff <= nxt_result;
    end
  end

  // Fast interrupt state
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff <= CSF_ST_NORMAL;
    end else begin
      case (state_ff)
        CSF_ST_NORMAL: begin
          if (nxt_flags[CSF_FIS_BIT]) begin
            state_ff <= CSF_ST_FAST;
          end
        end
        CSF_ST_FAST: begin
          if (!nxt_flags[CSF_FIS_BIT]) begin
            state_ff <= CSF_ST_NORMAL;
          end
        end
        default: begin
          state_ff <= CSF_ST_NORMAL;
        end
      endcase
    end
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (flag_rd) begin
      REG_RDATA_O <= flags_ff;
    end else begin
      REG_RDATA_O <= 8'h00;
    end
  end

  assign OP_RESULT_O   = result_ff;
  // Full flag byte; branch conditions must not use bit 3
  assign FLAGS_O       = flags_ff;
  assign INT_BLOCK_O   = flags_ff[CSF_FIS_BIT];
  assign FAST_RETURN_O = INT_RETURN_I && flags_ff[CSF_FIS_BIT];
  assign BANK_SEL_O    = flags_ff[CSF_BANK_BIT];

  // Operand range checks
  logic        wpair_even;
  logic        wpair_range;
  logic        rpair_even;
  logic        rpair_range;
  logic        wreg_range;
  logic        bitpos_range;
  logic [15:0] disp_sext;

  assign wpair_even   = !WPAIR_I[0];
  assign wpair_range  = (WPAIR_I <= CSF_WPAIR_MAX);
  assign rpair_even   = !RPAIR_I[0];
  assign rpair_range  = (RPAIR_I <= CSF_RPAIR_MAX);
  assign wreg_range   = (WREG_I <= CSF_WREG_MAX);
  assign bitpos_range = (BITPOS_I <= CSF_BITPOS_MAX);
  assign WPAIR_OK_O   = wpair_even && wpair_range;
  assign RPAIR_OK_O   = rpair_even && rpair_range;
  assign BITOPND_OK_O = wreg_range && bitpos_range;

  // Effective addresses
  assign disp_sext  = {{8{DISP_I[7]}}, DISP_I};
  assign REL_ADDR_O = NEXT_PC_I + disp_sext;
  assign XS_ADDR_O  = PAIR_VAL_I + disp_sext;
  assign XL_ADDR_O  = PAIR_VAL_I + LONG_OFS_I;

endmodule : csf_status_flags

// [verif/csf_status_flags_properties.sv]
/*
  Checker for the status flag block.
  Assumes the bind below and one clock domain.
*/
`timescale 1ns/1ps
module csf_status_flags_chk
  import csf_pkg::*;
(
  // Clock, reset, operation
  input wire logic       SYS_CLK_I,
  input wire logic       RST_I,
  input wire logic       OP_VALID_I,
  input wire logic [4:0] OP_CODE_I,
  // Interrupt sequencing
  input wire logic       FAST_INT_START_I,
  input wire logic       INT_RETURN_I,
  input wire logic       INT_BLOCK_O,
  input wire logic       FAST_RETURN_O,
  // Flags
  input wire logic [7:0] FLAGS_O,
  input wire logic       BANK_SEL_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  carry_set_a: assert property (OP_VALID_I && OP_CODE_I == CSF_OP_SCF |=> FLAGS_O[7])
    else $error("carry not set");
  carry_flip_a: assert property (OP_VALID_I && OP_CODE_I == CSF_OP_CCF
    |=> FLAGS_O[7] != $past(FLAGS_O[7])) else $error("carry not inverted");
  bank_one_a: assert property (OP_VALID_I && OP_CODE_I == CSF_OP_SB1 |=> BANK_SEL_O)
    else $error("bank one not selected");
  bank_zero_a: assert property (OP_VALID_I && OP_CODE_I == CSF_OP_SB0 |=> !FLAGS_O[0])
    else $error("bank zero not selected");
  fast_set_a: assert property (FAST_INT_START_I |=> FLAGS_O[1] && INT_BLOCK_O)
    else $error("fast bit not set");
  fast_clear_a: assert property (INT_RETURN_I && FLAGS_O[1] && !FAST_INT_START_I
    |-> FAST_RETURN_O ##1 !FLAGS_O[1]) else $error("fast bit not cleared");
  fast_path_a: assert property (FAST_RETURN_O == (INT_RETURN_I && FLAGS_O[1]))
    else $error("fast return wrong");
  logic_v_a: assert property (OP_VALID_I && OP_CODE_I inside {5'h05, 5'h06, 5'h07}
    |=> !FLAGS_O[4]) else $error("overflow not cleared");
endmodule : csf_status_flags_chk

bind csf_status_flags csf_status_flags_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
  .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I), .FAST_INT_START_I(FAST_INT_START_I),
  .INT_RETURN_I(INT_RETURN_I), .INT_BLOCK_O(INT_BLOCK_O), .FAST_RETURN_O(FAST_RETURN_O),
  .FLAGS_O(FLAGS_O), .BANK_SEL_O(BANK_SEL_O));

// [verif/cpu_status_flag_logic_tb_top.sv]
/*
  Self-checking bench for the status flag block.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module cpu_status_flag_logic_tb_top;
  import csf_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, ov = 0, fst = 0, ret = 0;
  logic [7:0]  addr = 0, wd = 0, a = 0, b = 0, rp = 0, dsp = 0, mf, kn;
  logic [4:0]  code = 0;
  logic [3:0]  wp = 0, wrg = 0;
  logic [2:0]  bt = 0, bp = 0;
  logic [15:0] pc = 0, pv = 0, lo = 0;
  wire  [7:0]  rdat, res, flg;
  wire  [15:0] rel, xs, xl;
  wire         blk, fret, bsel, wok, rok, bok;
  int          failures = 0, checked = 0, seed = 32'ha2f3_3527;

  csf_status_flags uut (.SYS_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .OP_VALID_I(ov), .OP_CODE_I(code),
    .OP_A_I(a), .OP_B_I(b), .OP_BIT_I(bt), .OP_RESULT_O(res), .FAST_INT_START_I(fst),
    .INT_RETURN_I(ret), .INT_BLOCK_O(blk), .FAST_RETURN_O(fret), .FLAGS_O(flg),
    .BANK_SEL_O(bsel), .WPAIR_I(wp), .RPAIR_I(rp), .WREG_I(wrg), .BITPOS_I(bp),
    .WPAIR_OK_O(wok), .RPAIR_OK_O(rok), .BITOPND_OK_O(bok), .NEXT_PC_I(pc), .DISP_I(dsp),
    .PAIR_VAL_I(pv), .LONG_OFS_I(lo), .REL_ADDR_O(rel), .XS_ADDR_O(xs), .XL_ADDR_O(xl));

  always #20 clk = ~clk;

  task automatic op(input int c, input int x, input int y, input int k);
    int r, hn, s, v, co;
    x = x & 255;
    y = y & 255;
    @(posedge clk);
    ov <= 1;
    code <= c[4:0];
    a <= x[7:0];
    b <= y[7:0];
    bt <= k[2:0];
    @(posedge clk);
    ov <= 0;
    #1;
    co = mf[7];
    r = 0;
    if (c <= 4) begin
      s = c > 2;
      if (c == 1 || c == 3) co = 0;
      r = s ? x - y - co : x + y + co;
      hn = s ? (x & 15) - (y & 15) - co : (x & 15) + (y & 15) + co;
      v = s ? (x[7] != y[7] && r[7] != x[7]) : (x[7] == y[7] && r[7] != x[7]);
      mf[7:2] = {r[8], r[7:0] == 0, r[7], v[0], s[0], hn[4]};
    end else if (c <= 7) begin
      r = c == 5 ? x & y : c == 6 ? x | y : x ^ y;
      mf[6:4] = {r[7:0] == 0, r[7], 1'b0};
      kn[4] = 1;
    end else if (c <= 12) begin
      case (c)
        8: r = {x[6:0], x[7]};
        9: r = {x[6:0], co[0]};
        10: r = {x[0], x[7:1]};
        11: r = {co[0], x[7:1]};
        default: r = {x[7], x[7:1]};
      endcase
      mf[7:5] = {c < 10 ? x[7] : x[0], r[7:0] == 0, r[7]};
    end else case (c)
      13: mf[6] = !x[k[2:0]];
      17: begin
        hn = (mf[2] || x[3:0] > 9 ? 6 : 0) + (mf[7] || x > 153 ? 96 : 0);
        r = mf[3] ? x - hn : x + hn;
        mf[7:5] = {mf[7] || (!mf[3] && x > 153), r[7:0] == 0, r[7]};
      end
      14: mf[7] = 1;
      15: mf[7] = 0;
      16: mf[7] = !mf[7];
      18: mf[0] = 0;
      default: mf[0] = 1;
    endcase
    `CHK(flg & kn, mf & kn)
    if (c <= 12 || c == 17) `CHK(res, r[7:0])
  endtask : op

  task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= ad;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    #1;
    if (ad === CSF_FLAGS_OFS) mf = d;
    kn = 8'hFF;
  endtask : wreg

  task automatic rreg(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= ad;
    @(posedge clk);
    rd <= 0;
    #1;
    `CHK(rdat, e)
  endtask : rreg

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  initial begin
    #200000;
    failures++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    mf = CSF_FLAGS_RST;
    kn = 8'hFF;
    #1 `CHK(flg, CSF_FLAGS_RST)
    op(1, 8'h7F, 8'h01, 0);
    op(2, 8'hFF, 8'h01, 0);
    op(3, 8'h80, 8'h01, 0);
    op(1, 8'h19, 8'h28, 0);
    op(17, 8'h41, 0, 0);
    op(3, 8'h42, 8'h15, 0);
    op(17, 8'h2D, 0, 0);
    for (int i = 1; i <= 19; i++) op(i, i * 37, i * 11, i);
    for (int i = 0; i < 300; i++) op(($random(seed) & 15) + 1, $random(seed), $random(seed), i);
    $display("Flag operations done");
    wreg(CSF_FLAGS_OFS, 8'h5A);
    `CHK(flg, 8'h5A)
    `CHK(bsel, 1'b0)
    rreg(CSF_FLAGS_OFS, 8'h5A);
    wreg(8'hD4, 8'hFF);
    rreg(8'hD4, 8'h00);
    rreg(CSF_FLAGS_OFS, 8'h5A);
    $display("Register access done");
    @(posedge clk);
    fst <= 1;
    @(posedge clk);
    fst <= 0;
    ret <= 1;
    #1 `CHK({flg[1], blk, fret}, 3'b111)
    @(posedge clk);
    ret <= 0;
    #1 `CHK({flg[1], blk}, 2'b00)
    $display("Fast interrupt done");
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      wp <= i[3:0];
      wrg <= i[5:2];
      bp <= i[2:0];
      rp <= $random(seed);
      dsp <= $random(seed);
      pc <= $random(seed);
      pv <= $random(seed);
      lo <= $random(seed);
      #1 `CHK({wok, rok, bok}, {!wp[0], !rp[0], 1'b1})
      `CHK(rel, pc + {{8{dsp[7]}}, dsp})
      `CHK(xs, pv + {{8{dsp[7]}}, dsp})
      `CHK(xl, pv + lo)
    end
    $display("Operand checks done");
    rst <= 1;
    repeat (3) @(posedge clk);
    #1 `CHK(flg, CSF_FLAGS_RST)
    final_report();
  end
endmodule : cpu_status_flag_logic_tb_top
